// [src/psb_bus_interface.sv]
// Processor-side system bus interface: issue, write data, arbitration, slave capture.
`timescale 1ns/1ps
module psb_bus_interface
  import psb_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  // Protocol strap
  input wire logic PROTOCOL_SELECT_N_IN,
  // Shared bus pins, split into input, output and enable
  input wire psb_cycle_t BUS_IN,
  output psb_cycle_t BUS_OUT,
  output logic BUS_OE_N_OUT,
  // Handshake pins
  input wire logic READ_READY_N_IN,
  input wire logic WRITE_READY_N_IN,
  input wire logic EXTERNAL_REQUEST_N_IN,
  input wire logic AGENT_VALID_N_IN,
  output logic PROCESSOR_VALID_N_OUT,
  output logic RELEASE_N_OUT,
  // Core request path
  input wire logic CORE_REQ_VALID_IN,
  input wire psb_req_t CORE_REQ_IN,
  output logic CORE_REQ_TAKEN_OUT,
  output logic CORE_ISSUED_OUT,
  input wire logic CORE_WDATA_VALID_IN,
  input wire psb_wdata_t CORE_WDATA_IN,
  output logic CORE_WDATA_ACK_OUT,
  // Core receive path
  output logic CORE_RX_VALID_OUT,
  output psb_cycle_t CORE_RX_OUT,
  output logic CORE_RX_PAR_ERR_OUT,
  input wire logic CORE_EXT_DONE_IN,
  input wire logic CORE_READ_DONE_IN,
  // Status
  output logic CORE_MASTER_OUT,
  output logic CORE_READ_PENDING_OUT
);

  // ==========================================================================
  // Input registers
  // Every pin is registered before use so the whole interface runs register to register.
  psb_cycle_t bus_in_q;
  logic [2:0] hs_q;
  logic [1:0] rdy_lag_q;

  psb_in_reg #(.W($bits(psb_cycle_t)), .DEPTH(IN_DEPTH), .RESET_VAL('0)) u_in_bus (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .d_in(BUS_IN),
    .q_out(bus_in_q)
  );

  psb_in_reg #(.W(3), .DEPTH(IN_DEPTH), .RESET_VAL(HS_RESET)) u_in_hs (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .d_in({PROTOCOL_SELECT_N_IN, AGENT_VALID_N_IN, EXTERNAL_REQUEST_N_IN}),
    .q_out(hs_q)
  );

  // The second stage lets the issue check see the ready level from two cycles before.
  psb_in_reg #(.W(2), .DEPTH(RDY_LEAD_CYCLES), .RESET_VAL(RDY_RESET)) u_in_rdy (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .d_in({WRITE_READY_N_IN, READ_READY_N_IN}),
    .q_out(rdy_lag_q)
  );

  // ==========================================================================
  // Decoded inputs
  wire proto_on = hs_q[2];
  wire ext_req = ~hs_q[0];
  wire agent_valid = ~hs_q[1];
  wire read_ready_lag2 = ~rdy_lag_q[0];
  wire write_ready_lag2 = ~rdy_lag_q[1];

  // ==========================================================================
  // State
  psb_state_t state_q;
  psb_state_t state_d;
  psb_req_t req_q;
  logic [BEAT_W-1:0] beats_q;
  logic read_pend_q;
  logic resume_q;

  // Output registers.
  psb_cycle_t bus_out_q;
  logic oe_n_q;
  logic valid_n_q;
  logic release_n_q;
  logic req_taken_q;
  logic issued_q;
  logic wack_q;
  logic rx_valid_q;
  psb_cycle_t rx_q;
  logic rx_par_err_q;
  logic master_q;

  // ==========================================================================
  // Issue qualification and request decisions
  wire issue_ok = req_q.write ? write_ready_lag2 : read_ready_lag2;
  wire in_idle = (state_q == ST_IDLE);
  wire in_issue = (state_q == ST_ISSUE);
  wire in_wdata = (state_q == ST_WDATA);
  wire in_slave = (state_q == ST_SLAVE);
  wire idle_release = in_idle && proto_on && (ext_req || read_pend_q);
  // New requests wait while a read is outstanding, so only one request is ever open.
  wire take_req = in_idle && proto_on && !ext_req && !read_pend_q && CORE_REQ_VALID_IN;
  // Only an address cycle that really stood on the pins can count. A protocol drop parks the
  // request instead of losing it: no cycle is shown or counted until the select returns.
  wire addr_shown = !valid_n_q;
  wire issue_done = in_issue && issue_ok && addr_shown;
  wire issue_abort = in_issue && !issue_ok && ext_req;
  wire read_issued = issue_done && !req_q.write;
  wire wbeat = in_wdata && CORE_WDATA_VALID_IN && !wack_q && proto_on;
  wire last_beat = wbeat && (beats_q == BEAT_ONE);
  wire slave_capture = in_slave && agent_valid;

  // ==========================================================================
  // Next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        // An external request wins over a new core request, so the agent is never starved.
        if (idle_release) begin
          state_d = ST_RELEASE;
        end else if (take_req) begin
          state_d = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (issue_done) begin
          if (!req_q.write) begin
            state_d = ST_RELEASE;
          end else if (req_q.beats != BEAT_NONE) begin
            state_d = ST_WDATA;
          end else begin
            state_d = ST_IDLE;
          end
        end else if (issue_abort) begin
          state_d = ST_RELEASE;
        end
      end
      ST_WDATA: begin
        if (last_beat) begin
          state_d = ST_IDLE;
        end
      end
      ST_RELEASE: begin
        state_d = ST_SLAVE;
      end
      ST_SLAVE: begin
        if (CORE_EXT_DONE_IN) begin
          state_d = ST_RETURN;
        end
      end
      ST_RETURN: begin
        // One idle cycle lets the agent's drivers turn off before ours come on.
        if (resume_q) begin
          state_d = ST_ISSUE;
        end else begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Next bus contents
  // The address is repeated in every cycle of the issue state, not only the first.
  wire drive_addr = (state_d == ST_ISSUE);
  wire master_d = (state_d == ST_IDLE) || (state_d == ST_ISSUE) || (state_d == ST_WDATA);
  wire oe_n_d = !(master_d && proto_on);
  wire valid_n_d = !((drive_addr || wbeat) && proto_on);
  wire release_n_d = !(state_d == ST_RELEASE);
  wire [AD_W-1:0] addr_src = take_req ? CORE_REQ_IN.address : req_q.address;
  wire [7:0] cmd_src = take_req ? CORE_REQ_IN.command : req_q.command;
  wire [CMD_W-1:0] cmd_next = drive_addr ? {CYCLE_ADDR, cmd_src} :
                              wbeat ? {CYCLE_DATA, CORE_WDATA_IN.data_id} : bus_out_q.command_bus;
  wire [AD_W-1:0] ad_next = drive_addr ? addr_src :
                            wbeat ? CORE_WDATA_IN.data : bus_out_q.addr_data_bus;
  wire [CHK_W-1:0] chk_next;
  wire cmd_par_next;

  // ==========================================================================
  // Parity generation and checking
  wire [CHK_W-1:0] rx_chk_calc;
  wire rx_cmd_par_calc;

  // Outgoing parity is worked from the next bus value, so it leaves in the same register as the data.
  genvar g;
  generate
    for (g = 0; g < CHK_W; g++) begin : g_byte_par
      psb_parity #(.W(8), .ODD(PARITY_ODD)) u_tx_chk (
        .data_in(ad_next[g*8 +: 8]),
        .par_out(chk_next[g])
      );
      psb_parity #(.W(8), .ODD(PARITY_ODD)) u_rx_chk (
        .data_in(bus_in_q.addr_data_bus[g*8 +: 8]),
        .par_out(rx_chk_calc[g])
      );
    end
  endgenerate

  psb_parity #(.W(CMD_W), .ODD(PARITY_ODD)) u_tx_cmd_par (
    .data_in(cmd_next),
    .par_out(cmd_par_next)
  );

  psb_parity #(.W(CMD_W), .ODD(PARITY_ODD)) u_rx_cmd_par (
    .data_in(bus_in_q.command_bus),
    .par_out(rx_cmd_par_calc)
  );

  wire rx_par_bad = (rx_chk_calc != bus_in_q.addr_data_check_bus) ||
                    (rx_cmd_par_calc != bus_in_q.command_parity);

  // ==========================================================================
  // Control registers
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      state_q <= ST_IDLE;
      req_q <= '0;
      beats_q <= BEAT_NONE;
      resume_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (take_req) begin
        req_q <= CORE_REQ_IN;
      end
      if (issue_done) begin
        beats_q <= req_q.beats;
      end else if (wbeat) begin
        beats_q <= beats_q - BEAT_ONE;
      end
      // A request parked by an external request comes back once the slave episode ends.
      if (issue_abort) begin
        resume_q <= 1'b1;
      end else if (state_d == ST_ISSUE) begin
        resume_q <= 1'b0;
      end
    end
  end

  // A read issued in the same cycle as the core's done wins, so no issue is lost.
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      read_pend_q <= 1'b0;
    end else if (read_issued) begin
      read_pend_q <= 1'b1;
    end else if (CORE_READ_DONE_IN) begin
      read_pend_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Output registers
  // Reset values keep the pins released and the strobes idle until the state machine runs.
  psb_cycle_t bus_out_d;

  assign bus_out_d = '{command_parity: cmd_par_next, command_bus: cmd_next,
                       addr_data_check_bus: chk_next, addr_data_bus: ad_next};

  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      bus_out_q <= '0;
    end else begin
      bus_out_q <= bus_out_d;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      oe_n_q <= 1'b1;
      valid_n_q <= 1'b1;
      release_n_q <= 1'b1;
    end else begin
      oe_n_q <= oe_n_d;
      valid_n_q <= valid_n_d;
      release_n_q <= release_n_d;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      master_q <= 1'b0;
    end else begin
      master_q <= master_d;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      req_taken_q <= 1'b0;
      issued_q <= 1'b0;
      wack_q <= 1'b0;
    end else begin
      req_taken_q <= take_req;
      issued_q <= issue_done;
      wack_q <= wbeat;
    end
  end

  // Cycles are only reported in slave state, where the agent owns the bus.
  wire rx_valid_d = slave_capture;
  wire rx_par_err_d = slave_capture && rx_par_bad;

  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      rx_valid_q <= 1'b0;
      rx_q <= '0;
      rx_par_err_q <= 1'b0;
    end else begin
      rx_valid_q <= rx_valid_d;
      if (slave_capture) begin
        rx_q <= bus_in_q;
      end
      rx_par_err_q <= rx_par_err_d;
    end
  end

  // ==========================================================================
  // Port drive
  assign BUS_OUT = bus_out_q;
  assign BUS_OE_N_OUT = oe_n_q;
  assign PROCESSOR_VALID_N_OUT = valid_n_q;
  assign RELEASE_N_OUT = release_n_q;
  assign CORE_REQ_TAKEN_OUT = req_taken_q;
  assign CORE_ISSUED_OUT = issued_q;
  assign CORE_WDATA_ACK_OUT = wack_q;
  assign CORE_RX_VALID_OUT = rx_valid_q;
  assign CORE_RX_OUT = rx_q;
  assign CORE_RX_PAR_ERR_OUT = rx_par_err_q;
  assign CORE_MASTER_OUT = master_q;
  assign CORE_READ_PENDING_OUT = read_pend_q;

endmodule : psb_bus_interface

// [src/psb_pkg.sv]
// Shared types and constants of the processor system bus interface.
// What this block does
// - Protocol select high enables this bus variant
// - 32-bit bus, 4-bit check, 9-bit command, parity
// - Address/data and command buses are bidirectional
// - Request is address cycle then data cycles
// - Only valid-strobed cycles count; command identifies content
// - Command bit 8: 0 address, 1 data
// - Master drives buses; slave means agent drives
// - Owner asserts its valid strobe for content
// - Read issues only if read-ready two cycles earlier
// - Write issues only if write-ready two cycles earlier
// - Repeat address cycle until issued; then data
// - Exactly one issue cycle per request
// - External request releases interface, even mid-issue
// - Interrupted request reissued after external request ends
// - All outputs come from output registers
// - All interface inputs captured in input registers
// - Stay master except arbitration or read self-release
// - Release strobe lasts exactly one cycle
// - Return to master when external request completes
// - Pending read makes processor release interface itself
package psb_pkg;

  // ==========================================================================
  // Bus field layout and encodings
  localparam int AD_W = 32;
  localparam int CHK_W = 4;
  localparam int CMD_W = 9;
  localparam int CMD_TYPE_BIT = 8;
  localparam int BEAT_W = 4;
  localparam logic CYCLE_ADDR = 1'b0;
  localparam logic CYCLE_DATA = 1'b1;
  // Parity sense is not settled; even parity until the system defines it.
  localparam logic PARITY_ODD = 1'b0;

  // ==========================================================================
  // Input register depths, handshake reset levels and beat counts
  localparam int IN_DEPTH = 1;
  localparam int RDY_LEAD_CYCLES = 2;
  localparam logic [2:0] HS_RESET = 3'h7;
  localparam logic [1:0] RDY_RESET = 2'h3;
  localparam logic [BEAT_W-1:0] BEAT_ONE = 4'h1;
  localparam logic [BEAT_W-1:0] BEAT_NONE = 4'h0;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic command_parity;
    logic [CMD_W-1:0] command_bus;
    logic [CHK_W-1:0] addr_data_check_bus;
    logic [AD_W-1:0] addr_data_bus;
  } psb_cycle_t;

  typedef struct packed {
    logic write;
    logic [7:0] command;
    logic [AD_W-1:0] address;
    logic [BEAT_W-1:0] beats;
  } psb_req_t;

  typedef struct packed {
    logic [7:0] data_id;
    logic [AD_W-1:0] data;
  } psb_wdata_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_WDATA,
    ST_RELEASE,
    ST_SLAVE,
    ST_RETURN
  } psb_state_t;

endpackage : psb_pkg

// [src/psb_in_reg.sv]
// Input register pipeline of configurable width and depth.
`timescale 1ns/1ps
module psb_in_reg #(
  parameter int W = 1,
  parameter int DEPTH = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [DEPTH-1:0][W-1:0] stage_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stage_q <= {DEPTH{RESET_VAL}};
    end else begin
      stage_q[0] <= d_in;
      for (int i = 1; i < DEPTH; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  assign q_out = stage_q[DEPTH-1];

endmodule : psb_in_reg

// [src/psb_parity.sv]
// Parity over one parameterised field.
`timescale 1ns/1ps
module psb_parity #(
  parameter int W = 8,
  parameter logic ODD = 1'b0
) (
  input wire logic [W-1:0] data_in,
  output logic par_out
);

  assign par_out = (^data_in) ^ ODD;

endmodule : psb_parity

// [tb/psb_monitor.sv]
// Concurrent checks on the ports of the system bus interface.
`timescale 1ns/1ps
module psb_monitor
  import psb_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  // Bus pins
  input wire logic PROTOCOL_SELECT_N_IN,
  input wire psb_cycle_t BUS_OUT,
  input wire logic BUS_OE_N_OUT,
  input wire logic READ_READY_N_IN,
  input wire logic WRITE_READY_N_IN,
  input wire logic AGENT_VALID_N_IN,
  input wire logic PROCESSOR_VALID_N_OUT,
  input wire logic RELEASE_N_OUT,
  // Core side
  input wire logic CORE_REQ_TAKEN_OUT,
  input wire logic CORE_ISSUED_OUT,
  input wire logic CORE_WDATA_ACK_OUT,
  input wire logic CORE_RX_VALID_OUT,
  input wire logic CORE_MASTER_OUT,
  input wire logic CORE_READ_PENDING_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  // ====================
  // Assertions
  a_release_one_cycle: assert property ($fell(RELEASE_N_OUT) |=> RELEASE_N_OUT)
    else $error("release strobe longer than one cycle");
  a_release_drops_bus: assert property (!RELEASE_N_OUT |-> BUS_OE_N_OUT && !CORE_MASTER_OUT)
    else $error("bus still driven in release cycle");
  a_slave_no_drive: assert property (!CORE_MASTER_OUT |-> BUS_OE_N_OUT)
    else $error("bus driven outside master state");
  a_valid_parity: assert property (!PROCESSOR_VALID_N_OUT |->
    !BUS_OE_N_OUT && BUS_OUT.command_parity == ^BUS_OUT.command_bus)
    else $error("valid cycle undriven or bad parity");
  a_addr_cycle_type: assert property (CORE_REQ_TAKEN_OUT |->
    !PROCESSOR_VALID_N_OUT && BUS_OUT.command_bus[CMD_TYPE_BIT] == CYCLE_ADDR)
    else $error("taken request without address cycle");
  a_data_cycle_type: assert property (CORE_WDATA_ACK_OUT |->
    !PROCESSOR_VALID_N_OUT && BUS_OUT.command_bus[CMD_TYPE_BIT] == CYCLE_DATA)
    else $error("write beat without data cycle");
  a_read_issue_ready: assert property (CORE_ISSUED_OUT && CORE_READ_PENDING_OUT |->
    !$past(READ_READY_N_IN, 3) && !RELEASE_N_OUT)
    else $error("read issued without ready or self release");
  a_write_issue_ready: assert property (CORE_ISSUED_OUT && !CORE_READ_PENDING_OUT |->
    !$past(WRITE_READY_N_IN, 3))
    else $error("write issued without ready");
  a_issue_once: assert property (CORE_ISSUED_OUT |-> !$past(PROCESSOR_VALID_N_OUT) ##1 !CORE_ISSUED_OUT[*2])
    else $error("issue not after one address cycle");
  a_rx_from_valid: assert property (CORE_RX_VALID_OUT |-> !$past(AGENT_VALID_N_IN, 2))
    else $error("receive without agent valid");
  a_proto_off_idle: assert property ((!PROTOCOL_SELECT_N_IN)[*3] |-> BUS_OE_N_OUT && PROCESSOR_VALID_N_OUT)
    else $error("active while protocol deselected");
  a_master_leaves: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN || !PROTOCOL_SELECT_N_IN)
    $fell(CORE_MASTER_OUT) |-> !RELEASE_N_OUT)
    else $error("master state left without release");
  c_read_issue: cover property (CORE_ISSUED_OUT && CORE_READ_PENDING_OUT);
  c_write_beat: cover property (CORE_WDATA_ACK_OUT);
  c_receive: cover property (CORE_RX_VALID_OUT && !CORE_READ_PENDING_OUT);
endmodule : psb_monitor

// [tb/psb_agent_model.sv]
// Behavioural external agent on the far side of the system bus.
`timescale 1ns/1ps
module psb_agent_model
  import psb_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Bench controls
  input wire logic rdy_ok_in,
  input wire logic ext_want_in,
  input wire psb_cycle_t pay_in,
  // Processor side
  input wire logic release_n_in,
  input wire logic oe_n_in,
  input wire psb_cycle_t drive_in,
  // Agent pins
  output logic read_ready_n_out,
  output logic write_ready_n_out,
  output logic ext_req_n_out,
  output logic valid_n_out,
  output psb_cycle_t pins_out
);
  logic drv_q;
  logic rdy_n_q;
  psb_cycle_t last_q;
  // ====================
  // Pins
  // A released bus shows the inverse of its last level, so a stale capture cannot pass as fresh.
  assign pins_out = !oe_n_in ? drive_in : (drv_q ? pay_in : ~last_q);
  assign valid_n_out = !drv_q;
  assign read_ready_n_out = rdy_n_q;
  assign write_ready_n_out = rdy_n_q;
  assign ext_req_n_out = !ext_want_in;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      drv_q <= 1'b0;
      rdy_n_q <= 1'b1;
      last_q <= '0;
    end else begin
      drv_q <= !release_n_in;
      rdy_n_q <= !rdy_ok_in;
      last_q <= pins_out;
    end
  end
endmodule : psb_agent_model

// [tb/test_processor_system_bus_interface.sv]
// Self-checking bench of the system bus interface against a behavioural agent.
`timescale 1ns/1ps
module test_processor_system_bus_interface
  import psb_pkg::*;
  ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel_n = 1'b1;
  psb_cycle_t pins, bus_o, rx;
  psb_cycle_t pay = '0;
  logic oe_n, rr_n, wr_n, ext_n, av_n, pv_n, rel_n, taken, issued, ack, rx_v, perr, master, rpend;
  logic rq_v = 1'b0;
  psb_req_t rq = '0;
  logic wd_v = 1'b0;
  psb_wdata_t wd = '0;
  logic ext_done = 1'b0;
  logic rd_done = 1'b0;
  logic rdy_ok = 1'b1;
  logic ext_want = 1'b0;
  int error_cnt = 0;
  int num_checks = 0;
  int i, t;
  always #20 clk = ~clk;
  psb_bus_interface dut (.REF_CLK_IN(clk), .RST_IN(rst), .PROTOCOL_SELECT_N_IN(psel_n), .BUS_IN(pins),
    .BUS_OUT(bus_o), .BUS_OE_N_OUT(oe_n), .READ_READY_N_IN(rr_n), .WRITE_READY_N_IN(wr_n),
    .EXTERNAL_REQUEST_N_IN(ext_n), .AGENT_VALID_N_IN(av_n), .PROCESSOR_VALID_N_OUT(pv_n),
    .RELEASE_N_OUT(rel_n), .CORE_REQ_VALID_IN(rq_v), .CORE_REQ_IN(rq), .CORE_REQ_TAKEN_OUT(taken),
    .CORE_ISSUED_OUT(issued), .CORE_WDATA_VALID_IN(wd_v), .CORE_WDATA_IN(wd), .CORE_WDATA_ACK_OUT(ack),
    .CORE_RX_VALID_OUT(rx_v), .CORE_RX_OUT(rx), .CORE_RX_PAR_ERR_OUT(perr), .CORE_EXT_DONE_IN(ext_done),
    .CORE_READ_DONE_IN(rd_done), .CORE_MASTER_OUT(master), .CORE_READ_PENDING_OUT(rpend));
  psb_agent_model agent (.clk_in(clk), .rst_in(rst), .rdy_ok_in(rdy_ok), .ext_want_in(ext_want),
    .pay_in(pay), .release_n_in(rel_n), .oe_n_in(oe_n), .drive_in(bus_o), .read_ready_n_out(rr_n),
    .write_ready_n_out(wr_n), .ext_req_n_out(ext_n), .valid_n_out(av_n), .pins_out(pins));
  // ====================
  // Helpers
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task tick;
    @(negedge clk);
  endtask : tick
  task chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task wait_ok(input logic ok);
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t wait ran out", $time);
      report_and_stop();
    end
  endtask : wait_ok
  // Even parity on the command, one even bit per byte on the check bus.
  function automatic psb_cycle_t mk(input logic [8:0] c, input logic [31:0] a, input logic b);
    psb_cycle_t r;
    r.addr_data_bus = a;
    r.command_bus = c;
    r.command_parity = ^c ^ b;
    for (int g = 0; g < 4; g++) r.addr_data_check_bus[g] = ^a[8*g+:8];
    return r;
  endfunction : mk
  // Called in the release cycle; the agent answers one cycle later.
  task automatic slave(input logic rd, input logic bad);
    int k;
    pay = mk({(rd ? CYCLE_DATA : CYCLE_ADDR), 8'($urandom)}, $urandom, bad);
    ext_want = 1'b0;
    for (k = 0; k < 20 && rx_v !== 1'b1; k++) tick();
    wait_ok(rx_v);
    chk(rx === pay && perr === bad, "received cycle wrong");
    ext_done = 1'b1;
    rd_done = rd;
    tick();
    ext_done = 1'b0;
    rd_done = 1'b0;
    for (k = 0; k < 20 && master !== 1'b1; k++) tick();
    wait_ok(master);
    chk(oe_n === 1'b0, "buses not taken back");
  endtask : slave
  task automatic req(input logic w, input logic [3:0] nb, input logic ab);
    psb_cycle_t a;
    int k, st, back;
    rq = '{w, 8'($urandom), $urandom, nb};
    a = mk({CYCLE_ADDR, rq.command}, rq.address, 1'b0);
    st = ab ? 30 : $urandom % 5;
    rdy_ok = (st == 0);
    back = 0;
    // The ready level reaches the issue check two cycles late; let it settle before asking.
    repeat (2) tick();
    rq_v = 1'b1;
    for (k = 0; k < 80 && taken !== 1'b1; k++) tick();
    wait_ok(taken);
    rq_v = 1'b0;
    for (k = 0; k < 80 && issued !== 1'b1; k++) begin
      if (rel_n === 1'b0) begin
        slave(1'b0, 1'($urandom));
        back = 1;
      end else if (pv_n === 1'b0) begin
        chk(bus_o === a, "address cycle changed");
        back = back ? 2 : 0;
      end
      if (k == st) rdy_ok = 1'b1;
      if (ab && k == 1) ext_want = 1'b1;
      tick();
    end
    wait_ok(issued);
    if (ab) chk(back == 2, "request not reissued");
    chk(rpend === !w, "pending read flag wrong");
    if (w) begin
      for (st = 0; st < nb; st++) begin
        wd = '{8'($urandom), $urandom};
        wd_v = 1'b1;
        tick();
        for (k = 0; k < 20 && ack !== 1'b1; k++) tick();
        wait_ok(ack);
        chk(bus_o === mk({CYCLE_DATA, wd.data_id}, wd.data, 1'b0) && pv_n === 1'b0, "bad beat");
      end
      wd_v = 1'b0;
    end else begin
      chk(rel_n === 1'b0, "no self release");
      slave(1'b1, 1'b0);
      chk(rpend === 1'b0, "read still pending");
    end
  endtask : req
  // ====================
  // Main sequence
  initial begin
    void'($urandom(32'hfc72));
    repeat (4) tick();
    rst = 1'b0;
    repeat (2) tick();
    chk(oe_n === 1'b0 && master === 1'b1, "not master after reset");
    psel_n = 1'b0;
    repeat (3) tick();
    rq_v = 1'b1;
    for (i = 0; i < 8; i++) begin
      tick();
      chk(taken !== 1'b1 && oe_n === 1'b1, "active while deselected");
    end
    rq_v = 1'b0;
    psel_n = 1'b1;
    repeat (4) tick();
    chk(master === 1'b1 && oe_n === 1'b0, "not back in master");
    for (t = 0; t < 20; t++) begin
      i = (t < 4) ? t : $urandom % 4;
      case (i)
        0: req(1'b1, 4'hF, 1'b0);
        1: req(1'b1, 4'h0, 1'b1);
        2: req(1'b0, 4'h0, 1'b1);
        default: req(1'($urandom), 4'($urandom % 4), 1'b0);
      endcase
      if (t % 5 == 4) begin
        ext_want = 1'b1;
        for (i = 0; i < 40 && rel_n !== 1'b0; i++) tick();
        wait_ok(rel_n === 1'b0);
        slave(1'b0, 1'($urandom));
      end
      $display("test %0d done", t);
    end
    report_and_stop();
  end
endmodule : test_processor_system_bus_interface
bind psb_bus_interface psb_monitor mon (.REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN),
  .PROTOCOL_SELECT_N_IN(PROTOCOL_SELECT_N_IN), .BUS_OUT(BUS_OUT), .BUS_OE_N_OUT(BUS_OE_N_OUT),
  .READ_READY_N_IN(READ_READY_N_IN), .WRITE_READY_N_IN(WRITE_READY_N_IN), .AGENT_VALID_N_IN(AGENT_VALID_N_IN),
  .PROCESSOR_VALID_N_OUT(PROCESSOR_VALID_N_OUT), .RELEASE_N_OUT(RELEASE_N_OUT),
  .CORE_REQ_TAKEN_OUT(CORE_REQ_TAKEN_OUT), .CORE_ISSUED_OUT(CORE_ISSUED_OUT),
  .CORE_WDATA_ACK_OUT(CORE_WDATA_ACK_OUT), .CORE_RX_VALID_OUT(CORE_RX_VALID_OUT),
  .CORE_MASTER_OUT(CORE_MASTER_OUT), .CORE_READ_PENDING_OUT(CORE_READ_PENDING_OUT));
